// File: design/hpmc_pkg.sv
// Constants and register map of the hot plug miscellaneous control bank
package hpmc_pkg;
  localparam int ADDR_W = 8;
  localparam int SLOTS = 6;
  localparam logic [7:0] OFF_MISC = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam int B_SCAN = 12;
  localparam int B_FAST = 11;
  localparam int B_FAULT = 10;
  localparam int B_SHUTOFF = 9;
  localparam int B_BUSY = 8;
  localparam int B_PAR = 7;
  localparam int B_SPEED = 6;
  localparam int B_ARB = 5;
  localparam int B_IDLE = 4;
  localparam int B_GIRQ = 3;
  localparam int B_OUTPUT_SHIFT_IRQ_FLAG = 2;
  localparam int B_OUTPUT_SHIFT_IRQ_ENABLE = 1;
  localparam int B_TRIG = 0;
  localparam int B_CFG_FAULT = 13;
  localparam int B_CFG_BUSY = 0;
  localparam int IRQ_W = 3;
  localparam int I_SHIFT = 0;
  localparam int I_ARB = 1;
  localparam int I_SHUTOFF = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [SLOTS-1:0] SLOT_RST = 6'h00;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_OFF, SEQ_ON} hpmc_seq_t;
endpackage

// File: design/hpmc_top.sv
// APB register bank and slot output sequencer of the hot plug misc control
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module hpmc_top #(
  parameter int SLOTS = hpmc_pkg::SLOTS
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [hpmc_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SCAN_IN_DONE_I,
  input wire logic GEN_IRQ_I,
  input wire logic ARB_TIMEOUT_I,
  input wire logic SHIFT_DONE_I,
  input wire logic [SLOTS-1:0] SLOT_REQ_I,
  input wire logic [SLOTS-1:0] SWITCH_OPEN_I,
  output logic SHIFT_START_O,
  output logic SEQ_ENABLE_PHASE_O,
  output logic [SLOTS-1:0] SLOT_ON_O,
  output logic INPUT_SCAN_DONE_O,
  output logic FAULT_ENABLE_O,
  output logic IRQ_O
);

  // Bus decode
  wire setup = PSEL_I & ~PENABLE_I & ~PREADY_O;
  wire access = PSEL_I & PENABLE_I & PREADY_O;
  wire wr = access & PWRITE_I;
  wire sel_misc = PADDR_I == hpmc_pkg::OFF_MISC;
  wire sel_cfg = PADDR_I == hpmc_pkg::OFF_CFG;
  wire sel_stat = PADDR_I == hpmc_pkg::OFF_IRQ_STAT;
  wire sel_mask = PADDR_I == hpmc_pkg::OFF_IRQ_MASK;
  wire mapped = sel_misc | sel_cfg | sel_stat | sel_mask;
  wire wr_misc = wr & sel_misc;
  wire wr_cfg = wr & sel_cfg;
  wire wr_stat = wr & sel_stat;
  wire wr_mask = wr & sel_mask;

  logic scan_q;
  logic fault_q;
  logic shutoff_q;
  logic busy_q;
  logic speed_q;
  logic arb_q;
  logic idle_q;
  logic girq_q;
  logic output_shift_irq_flag_q;
  logic output_shift_irq_enable_q;
  logic trig_q;
  logic cfg_seen_q;
  logic first_q;
  logic start_q;
  logic phase_q;
  logic [SLOTS-1:0] slot_q;
  logic [hpmc_pkg::IRQ_W-1:0] stat_q;
  logic [hpmc_pkg::IRQ_W-1:0] mask_q;
  hpmc_pkg::hpmc_seq_t st_q;
  hpmc_pkg::hpmc_seq_t st_d;

  // Trigger only starts from idle; a one while busy is dropped
  wire go = wr_misc & PWDATA_I[hpmc_pkg::B_TRIG] & ~trig_q;
  wire shift_ack = SHIFT_DONE_I & ~start_q;
  wire seq_done = (st_q == hpmc_pkg::SEQ_ON) & shift_ack;
  wire off_done = (st_q == hpmc_pkg::SEQ_OFF) & shift_ack;
  // Auto shutoff waits for idle so it never races the sequencer
  wire [SLOTS-1:0] auto_off = (st_q == hpmc_pkg::SEQ_IDLE && !shutoff_q) ?
                              (slot_q & SWITCH_OPEN_I) : '0;
  wire shut_evt = |auto_off;
  wire busy_d = ~(first_q | (seq_done & cfg_seen_q)) |
                (st_d != hpmc_pkg::SEQ_IDLE);
  wire [hpmc_pkg::IRQ_W-1:0] evt = {shut_evt, ARB_TIMEOUT_I, seq_done};
  wire [hpmc_pkg::IRQ_W-1:0] w1c = wr_stat ? PWDATA_I[hpmc_pkg::IRQ_W-1:0] : '0;

  wire [15:0] misc_rd = {3'h0, scan_q, 1'b1, fault_q, shutoff_q, busy_q,
                         1'b0, speed_q, arb_q, idle_q, girq_q, output_shift_irq_flag_q,
                         output_shift_irq_enable_q, trig_q};
  wire [15:0] cfg_rd = {2'h0, fault_q, 12'h000, busy_q};
  wire [31:0] rd_mux = sel_misc ? {16'h0000, misc_rd} :
                       sel_cfg ? {16'h0000, cfg_rd} :
                       sel_stat ? {29'h0, stat_q} :
                       sel_mask ? {29'h0, mask_q} : 32'h0;

  // Sequencer: always one disable pass, then one enable pass
  always_comb begin
    st_d = st_q;
    case (st_q)
      hpmc_pkg::SEQ_IDLE: begin
        if (go) begin
          st_d = hpmc_pkg::SEQ_OFF;
        end
      end
      hpmc_pkg::SEQ_OFF: begin
        if (off_done) begin
          st_d = hpmc_pkg::SEQ_ON;
        end
      end
      hpmc_pkg::SEQ_ON: begin
        if (seq_done) begin
          st_d = hpmc_pkg::SEQ_IDLE;
        end
      end
      default: st_d = hpmc_pkg::SEQ_IDLE;
    endcase
  end

  // Zero wait state slave; answer is registered in the setup cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & ~mapped;
      PRDATA_O <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      st_q <= hpmc_pkg::SEQ_IDLE;
      start_q <= 1'b0;
      phase_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      st_q <= st_d;
      start_q <= go | off_done;
      phase_q <= off_done ? 1'b1 : (go ? 1'b0 : phase_q);
      trig_q <= go | (trig_q & ~seq_done);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      slot_q <= hpmc_pkg::SLOT_RST;
    end else if (off_done) begin
      slot_q <= slot_q & SLOT_REQ_I;
    end else if (seq_done) begin
      slot_q <= slot_q | SLOT_REQ_I;
    end else begin
      slot_q <= slot_q & ~auto_off;
    end
  end

  // Plain storage bits
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      shutoff_q <= 1'b0;
      speed_q <= 1'b0;
      idle_q <= 1'b0;
      output_shift_irq_enable_q <= 1'b0;
    end else if (wr_misc) begin
      shutoff_q <= PWDATA_I[hpmc_pkg::B_SHUTOFF];
      speed_q <= PWDATA_I[hpmc_pkg::B_SPEED];
      idle_q <= PWDATA_I[hpmc_pkg::B_IDLE];
      output_shift_irq_enable_q <= PWDATA_I[hpmc_pkg::B_OUTPUT_SHIFT_IRQ_ENABLE];
    end
  end

  // One fault enable bit, written from either copy
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      fault_q <= 1'b0;
    end else if (wr_misc) begin
      fault_q <= PWDATA_I[hpmc_pkg::B_FAULT];
    end else if (wr_cfg) begin
      fault_q <= PWDATA_I[hpmc_pkg::B_CFG_FAULT];
    end
  end

  // Software set beats the scan logic clear in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      scan_q <= 1'b0;
    end else if (wr_misc && PWDATA_I[hpmc_pkg::B_SCAN]) begin
      scan_q <= 1'b1;
    end else if (SCAN_IN_DONE_I) begin
      scan_q <= 1'b0;
    end
  end

  // Flags that hardware sets: set wins over the write-one clear
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      arb_q <= 1'b0;
      output_shift_irq_flag_q <= 1'b0;
      girq_q <= 1'b0;
      stat_q <= '0;
      mask_q <= hpmc_pkg::IRQ_MASK_RST;
    end else begin
      arb_q <= ARB_TIMEOUT_I |
               (arb_q & ~(wr_misc & PWDATA_I[hpmc_pkg::B_ARB]));
      output_shift_irq_flag_q <= (seq_done & output_shift_irq_enable_q) |
                (output_shift_irq_flag_q & ~(wr_misc & PWDATA_I[hpmc_pkg::B_OUTPUT_SHIFT_IRQ_FLAG]));
      girq_q <= GEN_IRQ_I;
      stat_q <= evt | (stat_q & ~w1c);
      mask_q <= wr_mask ? PWDATA_I[hpmc_pkg::IRQ_W-1:0] : mask_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      cfg_seen_q <= 1'b0;
      first_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      cfg_seen_q <= cfg_seen_q | wr_cfg;
      first_q <= first_q | (seq_done & cfg_seen_q);
      busy_q <= busy_d;
    end
  end

  // Shift irq flag also feeds the line, independent of the status mask
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_q & mask_q) | output_shift_irq_flag_q;
    end
  end

  assign SHIFT_START_O = start_q;
  assign SEQ_ENABLE_PHASE_O = phase_q;
  assign SLOT_ON_O = slot_q;
  assign INPUT_SCAN_DONE_O = scan_q;
  assign FAULT_ENABLE_O = fault_q;

  // Checks
  a_trig_start: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    go |=> trig_q && start_q && !phase_q)
    else $error("trigger write did not start shift");
  a_trig_ignore: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr_misc && !PWDATA_I[hpmc_pkg::B_TRIG] && !trig_q) |=> !trig_q && !start_q)
    else $error("zero write changed trigger");
  a_trig_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    seq_done |=> !trig_q && st_q == hpmc_pkg::SEQ_IDLE)
    else $error("trigger not cleared at completion");
  a_off_first: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(SHIFT_START_O) && SEQ_ENABLE_PHASE_O |-> $past(st_q) == hpmc_pkg::SEQ_OFF)
    else $error("enable pass before disable pass");
  a_output_shift_irq_flag_set: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $fell(trig_q) && $past(output_shift_irq_enable_q) |-> output_shift_irq_flag_q)
    else $error("shift irq flag missed");
  a_output_shift_irq_flag_none: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !output_shift_irq_flag_q && !output_shift_irq_enable_q |=> !output_shift_irq_flag_q)
    else $error("shift irq without enable");
  a_arb_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (arb_q && wr_misc && PWDATA_I[hpmc_pkg::B_ARB] && !ARB_TIMEOUT_I) |=> !arb_q)
    else $error("arbiter flag not cleared");
  a_arb_set: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    ARB_TIMEOUT_I |=> arb_q)
    else $error("arbiter flag not set");
  a_scan_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    SCAN_IN_DONE_I && !wr_misc |=> !scan_q)
    else $error("scan done not cleared");
  a_busy_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !first_q |-> busy_q || $past(RESET_I))
    else $error("busy dropped before first update");
  a_busy_mirror: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    cfg_rd[hpmc_pkg::B_CFG_BUSY] == misc_rd[hpmc_pkg::B_BUSY])
    else $error("busy copies differ");
  a_fault_share: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_cfg |=> fault_q == $past(PWDATA_I[hpmc_pkg::B_CFG_FAULT]))
    else $error("fault enable not shared");
  a_auto_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == hpmc_pkg::SEQ_IDLE && !shutoff_q && |(slot_q & SWITCH_OPEN_I))
    |=> (slot_q & $past(SWITCH_OPEN_I)) == '0)
    else $error("open slot not shut off");
  a_girq_track: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    ##1 girq_q == $past(GEN_IRQ_I))
    else $error("general irq pending wrong");
  a_fixed_bits: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    misc_rd[hpmc_pkg::B_FAST] && !misc_rd[hpmc_pkg::B_PAR])
    else $error("fixed flags wrong");
  a_store_bits: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_misc |=> speed_q == $past(PWDATA_I[hpmc_pkg::B_SPEED]) &&
                idle_q == $past(PWDATA_I[hpmc_pkg::B_IDLE]))
    else $error("storage bits lost");
  a_busy_read: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    st_q != hpmc_pkg::SEQ_IDLE |-> trig_q)
    else $error("trigger reads idle while running");
  a_busy_run: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    st_q != hpmc_pkg::SEQ_IDLE |-> busy_q)
    else $error("busy low while sequencer runs");
  a_busy_reset: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $past(RESET_I) |-> busy_q)
    else $error("busy low after reset");
  a_cfg_rd_busy: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PREADY_O && sel_cfg && !PWRITE_I |-> PRDATA_O[hpmc_pkg::B_CFG_BUSY] == $past(busy_q))
    else $error("config copy busy read wrong");
  a_cfg_rd_fault: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PREADY_O && sel_cfg && !PWRITE_I |-> PRDATA_O[hpmc_pkg::B_CFG_FAULT] == $past(fault_q))
    else $error("config copy fault read wrong");
  a_misc_rd_trig: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PREADY_O && sel_misc && !PWRITE_I |-> PRDATA_O[hpmc_pkg::B_TRIG] == $past(trig_q))
    else $error("trigger read does not show busy");
  a_fast_read: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PREADY_O && sel_misc |-> PRDATA_O[hpmc_pkg::B_FAST] && !PRDATA_O[hpmc_pkg::B_PAR])
    else $error("fixed flags read wrong");
  a_irq_line: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    output_shift_irq_flag_q |=> IRQ_O)
    else $error("shift irq flag not on the line");
  a_start_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    SHIFT_START_O |=> !SHIFT_START_O)
    else $error("start longer than one cycle");
  a_on_after_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    off_done |=> SHIFT_START_O && SEQ_ENABLE_PHASE_O)
    else $error("enable pass did not follow disable pass");
  a_slot_off_pass: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    off_done |=> SLOT_ON_O == ($past(slot_q) & $past(SLOT_REQ_I)))
    else $error("disable pass result wrong");
  a_slot_on_pass: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    seq_done |=> SLOT_ON_O == ($past(slot_q) | $past(SLOT_REQ_I)))
    else $error("enable pass result wrong");
  a_shutoff_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    st_q == hpmc_pkg::SEQ_IDLE && shutoff_q |=> slot_q == $past(slot_q))
    else $error("slot changed with shutoff disabled");
  a_scan_set: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_misc && PWDATA_I[hpmc_pkg::B_SCAN] |=> scan_q)
    else $error("scan done not set by write");
  a_output_shift_irq_flag_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_misc && PWDATA_I[hpmc_pkg::B_OUTPUT_SHIFT_IRQ_FLAG] && !(seq_done && output_shift_irq_enable_q) |=> !output_shift_irq_flag_q)
    else $error("shift irq flag not cleared");
  a_arb_keep: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    arb_q && !(wr_misc && PWDATA_I[hpmc_pkg::B_ARB]) |=> arb_q)
    else $error("arbiter flag lost");
  a_trig_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    trig_q && !seq_done |=> trig_q)
    else $error("trigger cleared before completion");
  a_fault_misc: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_misc |=> fault_q == $past(PWDATA_I[hpmc_pkg::B_FAULT]))
    else $error("fault enable not written");
  a_store_keep: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !wr_misc |=> speed_q == $past(speed_q) && idle_q == $past(idle_q))
    else $error("storage bits changed");
  a_unmapped_err: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PREADY_O && !mapped |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped access not refused");

endmodule

// File: test/hpmc_shift_model.sv
// Behavioural serial shift chain that answers each pass after a set delay
`timescale 1ns/1ps
module hpmc_shift_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic phase_i,
  input wire logic [3:0] delay_i,
  output logic done_o,
  output int passes_o,
  output logic [1:0] order_o
);
  logic [3:0] cnt_q;
  // Done marks the last cycle of a pass, so a slow chain just counts longer
  assign done_o = (cnt_q == 4'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      passes_o <= 0;
      order_o <= 2'h0;
    end else if (start_i) begin
      cnt_q <= delay_i;
      passes_o <= passes_o + 1;
      order_o <= {order_o[0], phase_i};
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the hot plug misc control register bank
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, done, start, phase, scan_o, fault_o, irq;
  logic scan = 1'b0;
  logic gen = 1'b0;
  logic arb = 1'b0;
  logic [5:0] req = 6'h00;
  logic [5:0] sw = 6'h00;
  logic [5:0] slot_on;
  logic [3:0] dly = 4'h2;
  logic [1:0] order;
  int passes, p0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  hpmc_top hpmc_top_inst (.CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SCAN_IN_DONE_I(scan), .GEN_IRQ_I(gen),
    .ARB_TIMEOUT_I(arb), .SHIFT_DONE_I(done), .SLOT_REQ_I(req), .SWITCH_OPEN_I(sw),
    .SHIFT_START_O(start), .SEQ_ENABLE_PHASE_O(phase), .SLOT_ON_O(slot_on),
    .INPUT_SCAN_DONE_O(scan_o), .FAULT_ENABLE_O(fault_o), .IRQ_O(irq));
  hpmc_shift_model hpmc_shift_model_inst (.clk_i(clk), .rst_i(rst), .start_i(start),
    .phase_i(phase), .delay_i(dly), .done_o(done), .passes_o(passes), .order_o(order));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; ready and data are taken at the edge that sees
  // ready high, then one idle edge passes so the next call never reassigns psel at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 40);
    chk(32'(k < 40), 32'h1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h00, 32'h0900);
    rdc(8'h04, 32'h0001);
    wr(8'h04, 32'h2000);
    @(negedge clk);
    chk(32'(fault_o), 32'h1);
    @(posedge clk);
    rdc(8'h00, 32'h0D00);
    wr(8'h00, 32'h02DA);
    rdc(8'h00, 32'h0B52);
    rdc(8'h04, 32'h0001);
    $display("test registers done");
    req <= 6'h3C;
    p0 = passes;
    wr(8'h00, 32'h0253);
    rdc(8'h00, 32'h0B53);
    wr(8'h00, 32'h0253);
    idle();
    rdc(8'h00, 32'h0A56);
    rdc(8'h04, 32'h0000);
    @(negedge clk);
    chk(32'(passes - p0), 32'h2);
    chk(32'(order), 32'h1);
    chk(32'(slot_on), 32'h3C);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    wr(8'h00, 32'h0256);
    wr(8'h00, 32'h0252);
    rdc(8'h00, 32'h0A52);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    chk(32'(passes - p0), 32'h2);
    @(posedge clk);
    dly <= 4'h6;
    req <= 6'h03;
    wr(8'h00, 32'h0251);
    idle();
    rdc(8'h00, 32'h0A50);
    @(negedge clk);
    chk(32'(slot_on), 32'h03);
    chk(32'(irq), 32'h0);
    chk(32'(order), 32'h1);
    @(posedge clk);
    $display("test shift done");
    sw <= 6'h01;
    rdc(8'h00, 32'h0A50);
    @(negedge clk);
    chk(32'(slot_on), 32'h03);
    @(posedge clk);
    wr(8'h00, 32'h0050);
    rdc(8'h00, 32'h0850);
    rdc(8'h08, 32'h0005);
    @(negedge clk);
    chk(32'(slot_on), 32'h02);
    @(posedge clk);
    sw <= 6'h00;
    wr(8'h00, 32'h1050);
    rdc(8'h00, 32'h1850);
    @(negedge clk);
    chk(32'(scan_o), 32'h1);
    @(posedge clk);
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    rdc(8'h00, 32'h0850);
    arb <= 1'b1;
    @(posedge clk);
    arb <= 1'b0;
    rdc(8'h00, 32'h0870);
    wr(8'h0C, 32'h0002);
    rdc(8'h0C, 32'h0002);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    wr(8'h08, 32'h0007);
    rdc(8'h08, 32'h0000);
    wr(8'h00, 32'h0050);
    rdc(8'h00, 32'h0870);
    wr(8'h00, 32'h0070);
    rdc(8'h00, 32'h0850);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    // Pending bit lags the input by one edge, and read data is taken in setup
    gen <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0858);
    gen <= 1'b0;
    @(posedge clk);
    rdc(8'h00, 32'h0850);
    wr(8'h10, 32'hFFFF);
    chk(32'(err), 32'h1);
    rdc(8'h10, 32'h0000);
    chk(32'(err), 32'h1);
    $display("test events done");
    // Busy must survive a full sequence until a config copy write has been seen
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h00, 32'h0900);
    wr(8'h00, 32'h0003);
    idle();
    rdc(8'h00, 32'h0906);
    wr(8'h04, 32'h0000);
    rdc(8'h04, 32'h0001);
    wr(8'h00, 32'h0007);
    idle();
    rdc(8'h00, 32'h0806);
    @(negedge clk);
    chk(32'(slot_on), 32'h03);
    $display("test reset done");
    end_of_test();
  end
endmodule
